// [design/hsc_pkg.sv]
/*
 * Shared constants of the high-speed event counter block: register map,
 * control and status field positions, mode encodings.
 * Assumes a 32-bit register port with byte addresses, one word per register.
 */
package hsc_pkg;
    localparam int NUM_COUNTERS = 3;
    localparam int VALUE_W = 32;
    localparam int ADDR_W = 8;
    localparam int MODE_W = 4;

    // Register byte addresses
    localparam logic [7:0] ADDR_DEFINE = 8'h00;
    localparam logic [7:0] ADDR_CTRL_BASE = 8'h04;
    localparam logic [7:0] ADDR_CONTROL_OP = 8'h10;
    localparam logic [7:0] ADDR_PRESET_BASE = 8'h14;
    localparam logic [7:0] ADDR_VALUE_BASE = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h2c;
    localparam logic [7:0] ADDR_MASK = 8'h30;
    localparam logic [7:0] ADDR_STRIDE = 8'h04;

    // Define and control-op word fields
    localparam int DEF_IDX_LSB = 0;
    localparam int DEF_MODE_LSB = 4;

    // Control word fields
    localparam int CTL_ENABLE = 0;
    localparam int CTL_DIR = 1;
    localparam int CTL_RST_HI = 2;
    localparam int CTL_START_HI = 3;
    localparam int CTL_RATE_4X = 4;
    localparam int CTL_W = 5;
    localparam logic [CTL_W-1:0] CTL_RESET = 5'h0c;

    // Status and mask: equal-preset events low, reset events above
    localparam int STAT_EQ_LSB = 0;
    localparam int STAT_RST_LSB = 3;
    localparam int STAT_W = 6;

    // Mode groups and reset/start options
    localparam logic [3:0] MODE_MAX_FULL = 4'hb;
    localparam logic [3:0] MODES_PER_GROUP = 4'h3;
    localparam logic [3:0] GRP_INT_DIR = 4'h0;
    localparam logic [3:0] GRP_EXT_DIR = 4'h1;
    localparam logic [3:0] GRP_TWO_CLK = 4'h2;
    localparam logic [3:0] GRP_QUAD = 4'h3;
    localparam logic [3:0] OPT_NONE = 4'h0;
    localparam logic [3:0] OPT_RESET_START = 4'h2;

    // Pin roles within a counter's four inputs
    localparam int PIN_CLK = 0;
    localparam int PIN_DIR = 1;
    localparam int PIN_RST = 2;
    localparam int PIN_START = 3;
endpackage

// [design/high_speed_event_counter.sv]
/*
 * Three high-speed event counters behind a plain register port: one simple
 * counter with a single clock pin and two full counters with twelve modes.
 * Assumes asynchronous counter pins (synchronised here), a 100 MHz clock and
 * a register master that never overlaps read and write strobes.
 */
// The address-and-strobe port and the address map were left to the implementer.
// How it works
// - Define binds counter 0..2 to a mode; simple takes mode 0, full ones 0..11.
// - Control op for counter N loads its staged control bits into use.
// - Simple counter counts one clock pin, direction from a software bit.
// - Each full counter uses its own clock, direction, reset and start pins.
// - First full counter pins are clock, direction, reset, start in order.
// - Two-clock modes accept both clocks at full rate.
// - Quadrature modes count once or four times per cycle, selectable.
// - Both full counters run independently without disturbing each other.
// - Coincident up and down edges leave the value unchanged, no error.
// - Separated up and down edges each count once.
// - Current value is read-only, whole 32-bit word only.
// - Events raised on count equal to preset and on counter reset.
// - Full modes group in threes: none, reset, reset plus start.
// - Reset clears and holds; inactive start freezes; reset needs start active.
// - Direction bit or pin: zero counts down, one counts up.
// - Quadrature: A leading B counts up, B leading A counts down.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pin_sync #(
    parameter int W = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [W-1:0] pins,
    output logic [W-1:0] level_reg,
    output logic [W-1:0] prev_reg
);
    logic [W-1:0] meta_reg;

    if (W < 1) begin : g_check
        $error("Synchroniser width must be at least 1");
    end

    // Two stages before any logic reads a pin; the third only feeds edge finding
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_reg <= '0;
            level_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pins;
            level_reg <= meta_reg;
            prev_reg <= level_reg;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module counter_channel
    import hsc_pkg::*;
#(
    parameter bit FULL = 1'b1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] pins,
    input wire logic [MODE_W-1:0] mode,
    input wire logic run,
    input wire logic dir_bit,
    input wire logic rst_hi,
    input wire logic start_hi,
    input wire logic rate_4x,
    input wire logic [VALUE_W-1:0] preset,
    output logic [VALUE_W-1:0] value_reg,
    output logic eq_pulse_reg,
    output logic reset_pulse_reg
);
    logic [3:0] s2_reg;
    logic [3:0] s3_reg;
    logic clr_prev_reg;

    if (MODE_W != 4) begin : g_check
        $error("Mode field must be four bits wide");
    end

    // Zeroed stages match idle-low pins; a pin idling high shows one rise after reset
    pin_sync #(
        .W(4)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .pins(pins),
        .level_reg(s2_reg),
        .prev_reg(s3_reg)
    );

    wire logic [3:0] rise = s2_reg & ~s3_reg;
    // Simple counter ignores mode entirely
    wire logic [3:0] grp = FULL ? mode / MODES_PER_GROUP : GRP_INT_DIR;
    wire logic [3:0] opt = FULL ? mode % MODES_PER_GROUP : OPT_NONE;
    wire logic use_rst = opt != OPT_NONE;
    wire logic use_start = opt == OPT_RESET_START;
    wire logic rst_lvl = use_rst & (s2_reg[PIN_RST] == rst_hi);
    wire logic start_lvl = ~use_start | (s2_reg[PIN_START] == start_hi);
    // Reset counts only while start is active
    wire logic clr = run & rst_lvl & start_lvl;
    wire logic count_en = run & start_lvl & ~clr;

    wire logic int_inc = rise[PIN_CLK] & dir_bit;
    wire logic int_dec = rise[PIN_CLK] & ~dir_bit;
    wire logic ext_inc = rise[PIN_CLK] & s2_reg[PIN_DIR];
    wire logic ext_dec = rise[PIN_CLK] & ~s2_reg[PIN_DIR];
    // Same-cycle up and down edges cancel; any wider gap counts both
    wire logic two_inc = rise[PIN_CLK] & ~rise[PIN_DIR];
    wire logic two_dec = rise[PIN_DIR] & ~rise[PIN_CLK];
    wire logic chg_a = s2_reg[PIN_CLK] ^ s3_reg[PIN_CLK];
    wire logic chg_b = s2_reg[PIN_DIR] ^ s3_reg[PIN_DIR];
    // Exactly one phase moved; both at once is a lost step, ignored
    wire logic q_step = chg_a ^ chg_b;
    wire logic q_fwd = s2_reg[PIN_CLK] ^ s3_reg[PIN_DIR];
    wire logic q_inc = rate_4x ? (q_step & q_fwd) : (rise[PIN_CLK] & ~s2_reg[PIN_DIR]);
    wire logic q_dec = rate_4x ? (q_step & ~q_fwd) : (rise[PIN_CLK] & s2_reg[PIN_DIR]);

    wire logic sel_int = grp == GRP_INT_DIR;
    wire logic sel_ext = grp == GRP_EXT_DIR;
    wire logic sel_two = grp == GRP_TWO_CLK;
    wire logic sel_quad = grp == GRP_QUAD;
    // Groups are one-hot; a mode past the last group counts nothing
    wire logic inc = (sel_int & int_inc) | (sel_ext & ext_inc) |
                     (sel_two & two_inc) | (sel_quad & q_inc);
    wire logic dec = (sel_int & int_dec) | (sel_ext & ext_dec) |
                     (sel_two & two_dec) | (sel_quad & q_dec);

    wire logic [VALUE_W-1:0] value_next = clr ? '0 :
                                          (count_en & inc) ? value_reg + VALUE_W'(1) :
                                          (count_en & dec) ? value_reg - VALUE_W'(1) : value_reg;
    wire logic eq_hit = (value_next != value_reg) & (value_next == preset);

    always_ff @(posedge clock) begin
        if (rst) begin
            value_reg <= '0;
            clr_prev_reg <= 1'b0;
            eq_pulse_reg <= 1'b0;
            reset_pulse_reg <= 1'b0;
        end else begin
            value_reg <= value_next;
            clr_prev_reg <= clr;
            eq_pulse_reg <= eq_hit;
            reset_pulse_reg <= clr & ~clr_prev_reg;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module high_speed_event_counter
    import hsc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata_reg,
    output logic irq_reg,
    input wire logic simple_clk_pin,
    input wire logic [3:0] hw_a_pins,
    input wire logic [3:0] hw_b_pins
);
    if (VALUE_W != 32 || NUM_COUNTERS != 3) begin : g_check
        $error("Counter width must be 32 and count must be 3");
    end

    logic [NUM_COUNTERS-1:0] defined_reg;
    logic [MODE_W-1:0] mode_reg [NUM_COUNTERS];
    logic [CTL_W-1:0] ctl_stage_reg [NUM_COUNTERS];
    logic [CTL_W-1:0] ctl_act_reg [NUM_COUNTERS];
    logic [VALUE_W-1:0] preset_reg [NUM_COUNTERS];
    logic [STAT_W-1:0] status_reg;
    logic [STAT_W-1:0] mask_reg;
    logic [VALUE_W-1:0] value [NUM_COUNTERS];
    logic [NUM_COUNTERS-1:0] eq_ev;
    logic [NUM_COUNTERS-1:0] rst_ev;
    logic [3:0] pin_grp [NUM_COUNTERS];

    assign pin_grp[0] = {3'h0, simple_clk_pin};
    assign pin_grp[1] = hw_a_pins;
    assign pin_grp[2] = hw_b_pins;

    ////////////////////////////////////////////////////////////////////////////
    wire logic [1:0] wr_idx = wdata[DEF_IDX_LSB +: 2];
    wire logic [MODE_W-1:0] wr_mode = wdata[DEF_MODE_LSB +: MODE_W];
    wire logic idx_ok = wr_idx < 2'(NUM_COUNTERS);
    wire logic mode_max_ok = (wr_idx == 2'h0) ? (wr_mode == 4'h0) : (wr_mode <= MODE_MAX_FULL);
    wire logic hit_define = addr == ADDR_DEFINE;
    wire logic hit_op = addr == ADDR_CONTROL_OP;
    wire logic hit_status = addr == ADDR_STATUS;
    wire logic hit_mask = addr == ADDR_MASK;
    // A second define of the same counter is dropped
    wire logic def_ok = wr & hit_define & idx_ok & mode_max_ok;
    wire logic op_ok = wr & hit_op & idx_ok;
    wire logic stat_wr = wr & hit_status;
    wire logic mask_wr = wr & hit_mask;
    wire logic [STAT_W-1:0] events = {rst_ev, eq_ev};
    wire logic [STAT_W-1:0] clr_bits = stat_wr ? wdata[STAT_W-1:0] : '0;
    // New events win over a same-cycle write-one clear
    wire logic [STAT_W-1:0] status_next = (status_reg & ~clr_bits) | events;
    // A mask written this cycle already governs the interrupt, so irq never lags
    wire logic [STAT_W-1:0] mask_next = mask_wr ? wdata[STAT_W-1:0] : mask_reg;
    wire logic irq_next = |(status_next & mask_next);

    always_ff @(posedge clock) begin
        if (rst) begin
            defined_reg <= '0;
            status_reg <= '0;
            mask_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            if (def_ok && !defined_reg[wr_idx]) begin
                defined_reg[wr_idx] <= 1'b1;
            end
            status_reg <= status_next;
            if (mask_wr) begin
                mask_reg <= wdata[STAT_W-1:0];
            end
            irq_reg <= irq_next;
        end
    end

    for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
        localparam logic [7:0] CTL_ADDR = ADDR_CTRL_BASE + ADDR_STRIDE * 8'(i);
        localparam logic [7:0] PRE_ADDR = ADDR_PRESET_BASE + ADDR_STRIDE * 8'(i);
        wire logic sel = wr_idx == 2'(i);
        wire logic ctl_wr = wr & (addr == CTL_ADDR);
        wire logic pre_wr = wr & (addr == PRE_ADDR);

        always_ff @(posedge clock) begin
            if (rst) begin
                mode_reg[i] <= '0;
                ctl_stage_reg[i] <= CTL_RESET;
                ctl_act_reg[i] <= CTL_RESET;
                preset_reg[i] <= '0;
            end else begin
                if (def_ok && sel && !defined_reg[i]) begin
                    mode_reg[i] <= wr_mode;
                end
                if (ctl_wr) begin
                    ctl_stage_reg[i] <= wdata[CTL_W-1:0];
                end
                if (op_ok && sel) begin
                    ctl_act_reg[i] <= ctl_stage_reg[i];
                end
                if (pre_wr) begin
                    preset_reg[i] <= wdata[VALUE_W-1:0];
                end
            end
        end

        // Separate instances share nothing but the system clock and reset
        counter_channel #(
            .FULL(i != 0)
        ) u_chan (
            .clock(clock),
            .rst(rst),
            .pins(pin_grp[i]),
            .mode(mode_reg[i]),
            .run(defined_reg[i] & ctl_act_reg[i][CTL_ENABLE]),
            .dir_bit(ctl_act_reg[i][CTL_DIR]),
            .rst_hi(ctl_act_reg[i][CTL_RST_HI]),
            .start_hi(ctl_act_reg[i][CTL_START_HI]),
            .rate_4x(ctl_act_reg[i][CTL_RATE_4X]),
            .preset(preset_reg[i]),
            .value_reg(value[i]),
            .eq_pulse_reg(eq_ev[i]),
            .reset_pulse_reg(rst_ev[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Values sit only in the read path; writes to them fall on nothing
    wire logic [31:0] rd_word =
        hit_define ? 32'(defined_reg) :
        (addr == ADDR_CTRL_BASE) ? 32'(ctl_stage_reg[0]) :
        (addr == ADDR_CTRL_BASE + ADDR_STRIDE) ? 32'(ctl_stage_reg[1]) :
        (addr == ADDR_CTRL_BASE + 2 * ADDR_STRIDE) ? 32'(ctl_stage_reg[2]) :
        (addr == ADDR_PRESET_BASE) ? preset_reg[0] :
        (addr == ADDR_PRESET_BASE + ADDR_STRIDE) ? preset_reg[1] :
        (addr == ADDR_PRESET_BASE + 2 * ADDR_STRIDE) ? preset_reg[2] :
        (addr == ADDR_VALUE_BASE) ? value[0] :
        (addr == ADDR_VALUE_BASE + ADDR_STRIDE) ? value[1] :
        (addr == ADDR_VALUE_BASE + 2 * ADDR_STRIDE) ? value[2] :
        hit_status ? 32'(status_reg) :
        hit_mask ? 32'(mask_reg) : 32'h0;

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= rd ? rd_word : 32'h0;
        end
    end
endmodule

`default_nettype wire

// [tb/hsc_monitor.sv]
/* Checker on the top-level ports of the event counter block.
   Assumes the register master never raises rd and wr together. */
`timescale 1ns/1ps
`default_nettype none
module hsc_monitor
    import hsc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata_reg,
    input wire logic irq_reg
);
    logic [5:0] mask_sh;
    logic def_seen;
    wire value_addr = addr == ADDR_VALUE_BASE || addr == 8'h24 || addr == 8'h28;
    always_ff @(posedge clock) begin
        if (rst) begin
            mask_sh <= 6'h00;
            def_seen <= 1'b0;
        end else begin
            if (wr && addr == ADDR_MASK) mask_sh <= wdata[5:0];
            if (wr && addr == ADDR_DEFINE) def_seen <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    rdata_idle_a: assert property (!rd |=> rdata_reg == 32'h0)
        else $error("read data without a read");
    unmapped_read_a: assert property (rd && addr == 8'h34 |=> rdata_reg == 32'h0)
        else $error("unmapped read not zero");
    define_read_a: assert property (rd && addr == ADDR_DEFINE |=> rdata_reg[31:3] == 29'h0)
        else $error("define readback too wide");
    ctrl_read_a: assert property (rd && addr == ADDR_CTRL_BASE |=> rdata_reg[31:5] == 27'h0)
        else $error("control readback too wide");
    status_read_a: assert property (rd && addr == ADDR_STATUS |=> rdata_reg[31:6] == 26'h0)
        else $error("status readback too wide");
    value_idle_a: assert property (rd && value_addr && !def_seen |=> rdata_reg == 32'h0)
        else $error("undefined counter moved");
    irq_mask_a: assert property (irq_reg |-> (mask_sh | $past(mask_sh)) != 6'h0)
        else $error("interrupt with empty mask");
    irq_fall_a: assert property ($fell(irq_reg) |-> $past(wr))
        else $error("interrupt dropped without a write");
endmodule
bind high_speed_event_counter hsc_monitor i_mon(.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_reg(rdata_reg), .irq_reg(irq_reg));
`default_nettype wire

// [tb/encoder_model.sv]
/* Pulse source and quadrature encoder on the counter pins.
   Assumes the bench calls its tasks one at a time; pins rest low, except the start bit of hw_a_pins, which rests high. */
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
    input wire logic clock,
    output logic simple_clk_pin,
    output logic [3:0] hw_a_pins,
    output logic [3:0] hw_b_pins
);
    initial begin
        simple_clk_pin = 1'b0;
        hw_a_pins = 4'h8;
        hw_b_pins = 4'h0;
    end
    // Six clocks a level, 60 ns at the 100 MHz clock
    task automatic hold();
        repeat (6) @(posedge clock);
    endtask
    task automatic pulse_simple();
        @(posedge clock);
        simple_clk_pin <= 1'b1;
        hold();
        simple_clk_pin <= 1'b0;
        hold();
    endtask
    // Bit 0 up clock, bit 1 down clock; both at once tests coincidence
    task automatic pulse_b(input logic [1:0] m);
        @(posedge clock);
        hw_b_pins[1:0] <= m;
        hold();
        hw_b_pins[1:0] <= 2'b00;
        hold();
    endtask
    task automatic quad_a(input logic fwd, input int n);
        logic [7:0] s;
        s = fwd ? 8'h2d : 8'h1e;
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge clock);
                hw_a_pins[1:0] <= s[2*k +: 2];
                hold();
            end
        end
    endtask
    task automatic set_a_ctl(input logic r, input logic st);
        @(posedge clock);
        hw_a_pins[3:2] <= {st, r};
        hold();
    endtask
endmodule
`default_nettype wire

// [tb/tb_high_speed_event_counter.sv]
/* Self-checking bench for the event counter block.
   Assumes encoder_model drives all counter pins. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_high_speed_event_counter;
    import hsc_pkg::*;
    logic clock, rst, wr, rd, irq_reg, simple_clk_pin;
    logic [7:0] addr;
    logic [31:0] wdata, rdata_reg;
    logic [3:0] hw_a_pins, hw_b_pins;
    int mismatches = 0;
    int comparisons = 0;
    high_speed_event_counter i_dut(.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_reg(rdata_reg), .irq_reg(irq_reg), .simple_clk_pin(simple_clk_pin),
        .hw_a_pins(hw_a_pins), .hw_b_pins(hw_b_pins));
    encoder_model i_enc(.clock(clock), .simple_clk_pin(simple_clk_pin), .hw_a_pins(hw_a_pins),
        .hw_b_pins(hw_b_pins));
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        `CHK(n, e, rdata_reg)
    endtask
    task automatic chk_irq(input logic e);
        #1;
        `CHK("irq", e, irq_reg)
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        mismatches++;
        finish_test();
    end
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        {addr, wdata, wr, rd} = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd_chk("ctrl0", ADDR_CTRL_BASE, 32'h0000000c);
        rd_chk("value0", ADDR_VALUE_BASE, 32'h0);
        rd_chk("unmapped", 8'h34, 32'h0);
        wr_reg(ADDR_DEFINE, 32'h00000010);
        wr_reg(ADDR_DEFINE, 32'h00000003);
        rd_chk("define", ADDR_DEFINE, 32'h0);
        wr_reg(ADDR_DEFINE, 32'h0);
        wr_reg(ADDR_DEFINE, 32'h000000b1);
        wr_reg(ADDR_DEFINE, 32'h00000062);
        wr_reg(ADDR_DEFINE, 32'h00000002);
        rd_chk("define", ADDR_DEFINE, 32'h7);
        $display("test define done");
        wr_reg(ADDR_CTRL_BASE, 32'h0f);
        wr_reg(ADDR_CONTROL_OP, 32'h0);
        repeat (3) i_enc.pulse_simple();
        wr_reg(ADDR_CTRL_BASE, 32'h0d);
        wr_reg(ADDR_CONTROL_OP, 32'h0);
        i_enc.pulse_simple();
        rd_chk("value0", ADDR_VALUE_BASE, 32'h2);
        wr_reg(ADDR_VALUE_BASE, 32'hffffffff);
        rd_chk("value0", ADDR_VALUE_BASE, 32'h2);
        $display("test simple done");
        wr_reg(8'h1c, 32'h1);
        wr_reg(ADDR_MASK, 32'h04);
        wr_reg(8'h0c, 32'h0d);
        wr_reg(ADDR_CONTROL_OP, 32'h2);
        i_enc.pulse_b(2'b01);
        chk_irq(1'b1);
        i_enc.pulse_b(2'b01);
        i_enc.pulse_b(2'b10);
        i_enc.pulse_b(2'b11);
        rd_chk("value2", 8'h28, 32'h1);
        rd_chk("value1", 8'h24, 32'h0);
        wr_reg(ADDR_STATUS, 32'h04);
        chk_irq(1'b0);
        $display("test two clock done");
        wr_reg(8'h08, 32'h1f);
        wr_reg(ADDR_CONTROL_OP, 32'h1);
        i_enc.quad_a(1'b1, 2);
        i_enc.quad_a(1'b0, 1);
        rd_chk("value1", 8'h24, 32'h4);
        i_enc.set_a_ctl(1'b1, 1'b1);
        rd_chk("value1", 8'h24, 32'h0);
        i_enc.set_a_ctl(1'b0, 1'b0);
        i_enc.quad_a(1'b1, 1);
        rd_chk("value1", 8'h24, 32'h0);
        i_enc.set_a_ctl(1'b0, 1'b1);
        wr_reg(8'h08, 32'h0f);
        wr_reg(ADDR_CONTROL_OP, 32'h1);
        i_enc.quad_a(1'b1, 1);
        rd_chk("value1", 8'h24, 32'h1);
        $display("test quadrature done");
        rd_chk("status", ADDR_STATUS, 32'h12);
        chk_irq(1'b0);
        wr_reg(ADDR_MASK, 32'h12);
        chk_irq(1'b1);
        wr_reg(ADDR_STATUS, 32'h12);
        chk_irq(1'b0);
        rd_chk("status", ADDR_STATUS, 32'h0);
        $display("test interrupt done");
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rd_chk("define", ADDR_DEFINE, 32'h0);
        rd_chk("value1", 8'h24, 32'h0);
        chk_irq(1'b0);
        wr_reg(ADDR_DEFINE, 32'h00000041);
        rd_chk("define", ADDR_DEFINE, 32'h2);
        wr_reg(8'h08, 32'h05);
        wr_reg(ADDR_CONTROL_OP, 32'h1);
        i_enc.set_a_ctl(1'b0, 1'b0);
        i_enc.quad_a(1'b0, 3);
        i_enc.quad_a(1'b1, 1);
        rd_chk("value1", 8'h24, 32'h2);
        i_enc.set_a_ctl(1'b1, 1'b0);
        rd_chk("value1", 8'h24, 32'h0);
        rd_chk("status", ADDR_STATUS, 32'h12);
        $display("test external direction done");
        finish_test();
    end
endmodule
`default_nettype wire
